/* File: osc_ctrl_defs.svh */
// offsets, field positions, keys and reset values of the oscillator control block
`ifndef OSC_CTRL_DEFS_SVH
`define OSC_CTRL_DEFS_SVH

`define OFFS_OSC_CONTROL   8'h00
`define OFFS_TRIM_SEQ_A    8'h04
`define OFFS_TRIM_SEQ_B    8'h08
`define OFFS_RANDOM_TRIM   8'h0C

`define CUR_GRP_LSB        12
`define NEXT_GRP_LSB       8
`define CFG_LOCK_BIT       7
`define PLL_LOCK_BIT       5
`define DITHER_BIT         4
`define FAIL_BIT           3
`define SEQ_EN_BIT         2
`define SWITCH_REQ_BIT     0

`define KEY_LO_FIRST       8'h46
`define KEY_LO_SECOND      8'h57
`define KEY_HI_FIRST       8'h78
`define KEY_HI_SECOND      8'h9A

`define GROUP_RC           3'h0
`define RESET_TRIM_REG     16'h0000
`define RESET_RANDOM       15'h0000
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* File: osc_ctrl_pkg.sv */
// types shared by the oscillator control block
package osc_ctrl_pkg;
  typedef logic [2:0] clock_group_t;
  typedef logic [3:0] trim_t;
  typedef enum logic [2:0] {UNLOCK_IDLE, LO_KEY_SEEN, LO_OPEN, HI_KEY_SEEN, HI_OPEN} unlock_state_e;
  typedef enum logic {SW_IDLE, SW_WAIT} switch_state_e;
endpackage : osc_ctrl_pkg

/* File: osc_ctrl.sv */
// oscillator switch, lock, fail flag and rc trim control with an axi4-lite register slave
//
// Summary of operation
// - current group bits 14-12 read-only; 000 rc, 001 rc+pll, 010 primary, 011 primary+pll.
// - reset forces the current group to the internal rc code.
// - a completed switch copies the next group into the current group.
// - a monitored clock failure forces the current group back to internal rc.
// - next group bits 10-8 are software writable and loaded from configuration at reset.
// - lock bit with upper monitor config bit set blocks clock and pll changes.
// - once set, the lock bit ignores clearing writes until reset.
// - pll lock flag clears on reset, switch start, lock loss; sets on lock.
// - pll lock flag reads zero unless a pll group is the current clock.
// - bit 4 enables pseudo-random clock dithering.
// - fail flag set by monitor failure, cleared by reset or switch start, software clearable.
// - with dither off, sequencer bit set picks trim by roll index; clear uses only base trim.
// - roll index 001 to 111 selects trim steps one to seven.
// - software writes 1 to request a switch; reads 0 once complete.
// - switch request clears on reset, switch done, redundant switch, fail fallback.
// - trim codes are signed: 0111 max, 0000 centre, 1000 min frequency.
// - random trim register is 15 bits read/write, top bit reads zero.
// - low byte write needs keys 46h then 57h immediately before it.
// - high byte write needs keys 78h then 9Ah immediately before it.
// - config upper bit disables switching and monitor; 01 switching only; 00 both.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "osc_ctrl_defs.svh"

module osc_ctrl #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]         awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  // axi4-lite write data
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  // axi4-lite write response
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]         araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // configuration settings
  input  wire logic [1:0]                initial_group,
  input  wire logic [1:0]                switch_monitor_cfg,
  // oscillator status and pwm roll index
  input  wire logic                      pll_locked,
  input  wire logic                      clock_fail_detect,
  input  wire logic                      switch_ready,
  input  wire logic [2:0]                roll_index,
  // oscillator control outputs
  output osc_ctrl_pkg::clock_group_t     current_clock_group,
  output osc_ctrl_pkg::clock_group_t     switch_target,
  output logic                           switch_busy,
  output osc_ctrl_pkg::trim_t            rc_trim
);

  if (ADDR_W < 4) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  function automatic logic is_pll_group(input osc_ctrl_pkg::clock_group_t grp);
    return grp[0] && !grp[2];
  endfunction : is_pll_group

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  function automatic logic [14:0] random_trim_value_step(input logic [14:0] val);
    if (val == `RESET_RANDOM) begin
      return 15'h0001;
    end
    return {val[13:0], val[14] ^ val[13]};
  endfunction : random_trim_value_step

  // bus state
  logic                          awready_reg;
  logic                          wready_reg;
  logic                          aw_hold_reg;
  logic                          w_hold_reg;
  logic [ADDR_W-1:0]             aw_addr_reg;
  logic [31:0]                   w_data_reg;
  logic [3:0]                    w_strb_reg;
  logic                          bvalid_reg;
  logic [1:0]                    bresp_reg;
  logic                          arready_reg;
  logic                          rvalid_reg;
  logic [31:0]                   rdata_reg;
  logic [1:0]                    rresp_reg;
  // block state
  osc_ctrl_pkg::clock_group_t    cur_reg;
  osc_ctrl_pkg::clock_group_t    next_reg;
  logic                          cfg_loaded_reg;
  logic                          lock_reg;
  logic                          pll_flag_reg;
  logic                          dither_reg;
  logic                          fail_reg;
  logic                          seq_reg;
  logic                          req_reg;
  logic                          busy_reg;
  logic [15:0]                   trim_a_reg;
  logic [15:0]                   trim_b_reg;
  logic [14:0]                   random_trim_value_reg;
  osc_ctrl_pkg::trim_t           trim_reg;
  osc_ctrl_pkg::unlock_state_e   unlock_reg;
  osc_ctrl_pkg::unlock_state_e   unlock_next;
  osc_ctrl_pkg::unlock_state_e   unlock_restart;
  osc_ctrl_pkg::switch_state_e   sw_reg;

  // bus decode
  wire                aw_take   = awvalid && awready_reg;
  wire                w_take    = wvalid && wready_reg;
  wire                ar_take   = arvalid && arready_reg;
  wire                b_done    = bvalid_reg && bready;
  wire                r_done    = rvalid_reg && rready;
  wire                commit    = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire [7:0]          wa        = 8'(aw_addr_reg);
  wire [7:0]          ra        = 8'(araddr);
  wire                wr_osc    = commit && (wa == `OFFS_OSC_CONTROL);
  wire                wr_trim_a = commit && (wa == `OFFS_TRIM_SEQ_A);
  wire                wr_trim_b = commit && (wa == `OFFS_TRIM_SEQ_B);
  wire                wr_random = commit && (wa == `OFFS_RANDOM_TRIM);
  wire                wr_mapped = wr_osc || wr_trim_a || wr_trim_b || wr_random;
  wire                rd_mapped = (ra == `OFFS_OSC_CONTROL) || (ra == `OFFS_TRIM_SEQ_A) ||
                                  (ra == `OFFS_TRIM_SEQ_B) || (ra == `OFFS_RANDOM_TRIM);

  // unlock key decode
  wire                lo_key_a  = wr_osc && (w_strb_reg == 4'h1) && (w_data_reg[7:0] == `KEY_LO_FIRST);
  wire                lo_key_b  = wr_osc && (w_strb_reg == 4'h1) && (w_data_reg[7:0] == `KEY_LO_SECOND);
  wire                hi_key_a  = wr_osc && (w_strb_reg == 4'h2) && (w_data_reg[15:8] == `KEY_HI_FIRST);
  wire                hi_key_b  = wr_osc && (w_strb_reg == 4'h2) && (w_data_reg[15:8] == `KEY_HI_SECOND);
  wire                lo_write  = wr_osc && w_strb_reg[0] && (unlock_reg == osc_ctrl_pkg::LO_OPEN);
  wire                hi_write  = wr_osc && w_strb_reg[1] && (unlock_reg == osc_ctrl_pkg::HI_OPEN);

  // switch and monitor decode
  wire                cfg_locked   = lock_reg && switch_monitor_cfg[1];
  wire                switch_allow = !switch_monitor_cfg[1];
  wire                fail_event   = clock_fail_detect && (switch_monitor_cfg == 2'h0);
  wire                sw_idle      = (sw_reg == osc_ctrl_pkg::SW_IDLE);
  // a request towards a reserved group is dropped like a redundant one
  wire                redundant    = sw_idle && req_reg && !fail_event && ((next_reg == cur_reg) || next_reg[2]);
  wire                sw_start     = sw_idle && req_reg && !fail_event && (next_reg != cur_reg) && !next_reg[2];
  wire                sw_complete  = !sw_idle && switch_ready && !fail_event;
  wire                req_set      = lo_write && w_data_reg[`SWITCH_REQ_BIT] && switch_allow && !cfg_locked && sw_idle;
  wire                req_clear    = fail_event || redundant || sw_complete;
  wire                fail_next    = fail_event ? 1'b1 :
                                     (sw_start || (lo_write && !w_data_reg[`FAIL_BIT])) ? 1'b0 : fail_reg;
  wire                pll_next     = !sw_start && !fail_event && sw_idle && pll_locked &&
                                     is_pll_group(cur_reg);
  wire [31:0]         trim_table   = {trim_b_reg, trim_a_reg};
  wire [3:0]          seq_trim     = trim_table[{roll_index, 2'b00} +: 4];
  wire [3:0]          trim_next    = dither_reg ? random_trim_value_reg[3:0] :
                                     seq_reg ? seq_trim : trim_a_reg[3:0];
  wire [15:0]         osc_word     = {1'b0, cur_reg, 1'b0, next_reg, lock_reg, 1'b0, pll_flag_reg,
                                      dither_reg, fail_reg, seq_reg, 1'b0, req_reg};
  wire [31:0]         read_word    = (ra == `OFFS_OSC_CONTROL) ? {16'h0000, osc_word} :
                                     (ra == `OFFS_TRIM_SEQ_A)  ? {16'h0000, trim_a_reg} :
                                     (ra == `OFFS_TRIM_SEQ_B)  ? {16'h0000, trim_b_reg} :
                                     (ra == `OFFS_RANDOM_TRIM) ? {17'h00000, random_trim_value_reg} : 32'h00000000;

  assign unlock_restart = lo_key_a ? osc_ctrl_pkg::LO_KEY_SEEN :
                          hi_key_a ? osc_ctrl_pkg::HI_KEY_SEEN : osc_ctrl_pkg::UNLOCK_IDLE;

  // any write between the keys and the target write closes the window
  always_comb begin
    unlock_next = unlock_reg;
    if (commit) begin
      case (unlock_reg)
        osc_ctrl_pkg::LO_KEY_SEEN: unlock_next = lo_key_b ? osc_ctrl_pkg::LO_OPEN : unlock_restart;
        osc_ctrl_pkg::HI_KEY_SEEN: unlock_next = hi_key_b ? osc_ctrl_pkg::HI_OPEN : unlock_restart;
        default:                   unlock_next = unlock_restart;
      endcase
    end
  end

  // axi4-lite write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        awready_reg <= 1'b0;
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (w_take) begin
        wready_reg <= 1'b0;
        w_hold_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (commit) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (b_done) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // axi4-lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= `RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= read_word;
      rresp_reg   <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (r_done) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // clock group, switch request and switch state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_reg        <= `GROUP_RC;
      next_reg       <= `GROUP_RC;
      cfg_loaded_reg <= 1'b0;
      req_reg        <= 1'b0;
      sw_reg         <= osc_ctrl_pkg::SW_IDLE;
      busy_reg       <= 1'b0;
      unlock_reg     <= osc_ctrl_pkg::UNLOCK_IDLE;
    end else begin
      unlock_reg     <= unlock_next;
      cfg_loaded_reg <= 1'b1;
      if (!cfg_loaded_reg) begin
        next_reg <= {1'b0, initial_group};
      end else if (hi_write && !cfg_locked) begin
        next_reg <= w_data_reg[`NEXT_GRP_LSB +: 3];
      end
      if (fail_event) begin
        cur_reg <= `GROUP_RC;
      end else if (sw_complete) begin
        cur_reg <= next_reg;
      end
      if (req_clear) begin
        req_reg <= 1'b0;
      end else if (req_set) begin
        req_reg <= 1'b1;
      end
      if (sw_start) begin
        sw_reg   <= osc_ctrl_pkg::SW_WAIT;
        busy_reg <= 1'b1;
      end else if (!sw_idle && (fail_event || switch_ready)) begin
        sw_reg   <= osc_ctrl_pkg::SW_IDLE;
        busy_reg <= 1'b0;
      end
    end
  end

  // status flags, control bits and trim
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_reg     <= 1'b0;
      pll_flag_reg <= 1'b0;
      dither_reg   <= 1'b0;
      fail_reg     <= 1'b0;
      seq_reg      <= 1'b0;
      trim_a_reg   <= `RESET_TRIM_REG;
      trim_b_reg   <= `RESET_TRIM_REG;
      random_trim_value_reg     <= `RESET_RANDOM;
      trim_reg     <= 4'h0;
    end else begin
      pll_flag_reg <= pll_next;
      fail_reg     <= fail_next;
      trim_reg     <= trim_next;
      if (lo_write) begin
        lock_reg   <= lock_reg | w_data_reg[`CFG_LOCK_BIT];
        dither_reg <= w_data_reg[`DITHER_BIT];
        seq_reg    <= w_data_reg[`SEQ_EN_BIT];
      end
      if (wr_trim_a) begin
        trim_a_reg <= merge16(trim_a_reg, w_data_reg, w_strb_reg);
      end
      if (wr_trim_b) begin
        trim_b_reg <= merge16(trim_b_reg, w_data_reg, w_strb_reg);
      end
      if (wr_random) begin
        random_trim_value_reg <= 15'(merge16({1'b0, random_trim_value_reg}, w_data_reg, w_strb_reg));
      end else if (dither_reg) begin
        random_trim_value_reg <= random_trim_value_step(random_trim_value_reg);
      end
    end
  end

  assign awready             = awready_reg;
  assign wready              = wready_reg;
  assign bvalid              = bvalid_reg;
  assign bresp               = bresp_reg;
  assign arready             = arready_reg;
  assign rvalid              = rvalid_reg;
  assign rdata               = rdata_reg;
  assign rresp               = rresp_reg;
  assign current_clock_group = cur_reg;
  assign switch_target       = next_reg;
  assign switch_busy         = busy_reg;
  assign rc_trim             = trim_reg;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence switch_begins;
    sw_start && !fail_event;
  endsequence

  sequence switch_lands;
    sw_complete;
  endsequence

  AST_CUR_LEGAL: assert property (cur_reg[2] == 1'b0)
    else $error("current group holds a reserved code");
  AST_RESET_RC: assert property (disable iff (1'b0) !aresetn |=> cur_reg == `GROUP_RC && !req_reg)
    else $error("reset did not force internal rc");
  AST_SWITCH_COPY: assert property (switch_lands |=> cur_reg == $past(next_reg) && !req_reg && !busy_reg)
    else $error("completed switch did not load the next group");
  AST_FAIL_FALLBACK: assert property (fail_event |=> cur_reg == `GROUP_RC && fail_reg && !req_reg)
    else $error("clock failure did not fall back to rc");
  AST_LOCK_STICKY: assert property (lock_reg |=> lock_reg)
    else $error("lock bit cleared without reset");
  AST_LOCK_BLOCKS: assert property (cfg_locked && cfg_loaded_reg |=> $stable(next_reg))
    else $error("next group changed while locked");
  AST_PLL_ZERO: assert property (!is_pll_group(cur_reg) |-> !pll_flag_reg)
    else $error("pll flag set without pll group");
  AST_START_CLEARS: assert property (switch_begins |=> !pll_flag_reg ##1 busy_reg || !req_reg)
    else $error("switch start did not clear pll flag");
  AST_FAIL_SET_WINS: assert property (fail_event && lo_write |=> fail_reg)
    else $error("fail flag set lost to a clear");
  AST_TRIM_SEQ: assert property (!dither_reg && seq_reg && roll_index == 3'h0 |=> rc_trim == $past(trim_a_reg[3:0]))
    else $error("roll index zero did not pick base trim");
  AST_TRIM_BASE: assert property (!dither_reg && !seq_reg |=> rc_trim == $past(trim_a_reg[3:0]))
    else $error("base trim not applied");
  AST_NO_KEY: assert property (wr_osc && w_strb_reg[0] && unlock_reg != osc_ctrl_pkg::LO_OPEN
                               |=> $stable(dither_reg) && $stable(seq_reg))
    else $error("low byte written without keys");
  AST_RANDOM_TOP: assert property (rvalid_reg && $past(ar_take) && $past(ra) == `OFFS_RANDOM_TRIM |-> rdata_reg[31:15] == '0)
    else $error("random trim top bit not zero");

endmodule : osc_ctrl

/* File: osc_ctrl_tb_top.sv */
// self-checking testbench of the oscillator control block
`timescale 1ns/100ps
`include "osc_ctrl_defs.svh"

module osc_ctrl_tb_top;
  logic                        aclk = 1'b0;
  logic                        aresetn = 1'b0;
  logic [7:0]                  awaddr = 8'h00, araddr = 8'h00;
  logic                        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic                        bready = 1'b1, rready = 1'b1;
  logic [31:0]                 wdata = 32'h0;
  logic [3:0]                  wstrb = 4'h0;
  logic                        awready, wready, bvalid, arready, rvalid, switch_busy;
  logic [1:0]                  bresp, rresp;
  logic [31:0]                 rdata;
  logic [1:0]                  initial_group = 2'h0, switch_monitor_cfg = 2'h0;
  logic                        pll_locked = 1'b0, clock_fail_detect = 1'b0, switch_ready = 1'b0;
  logic [2:0]                  roll_index = 3'h0;
  osc_ctrl_pkg::clock_group_t  current_clock_group, switch_target;
  osc_ctrl_pkg::trim_t         rc_trim;
  int                          err_count = 0, checked = 0, cycles = 0;

  osc_ctrl #(.ADDR_W(8)) DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .initial_group(initial_group),
    .switch_monitor_cfg(switch_monitor_cfg), .pll_locked(pll_locked), .clock_fail_detect(clock_fail_detect),
    .switch_ready(switch_ready), .roll_index(roll_index), .current_clock_group(current_clock_group),
    .switch_target(switch_target), .switch_busy(switch_busy), .rc_trim(rc_trim));

  always #5 aclk = ~aclk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // expected control word from its fields
  function automatic logic [31:0] ctl(input logic [2:0] c, input logic [2:0] n, input logic [7:0] lo);
    return {16'h0000, 1'b0, c, 1'b0, n, lo};
  endfunction : ctl

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw_d, w_d, b_d;
    aw_d = 1'b0; w_d = 1'b0; b_d = 1'b0;
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!b_d) begin
      @(posedge aclk);
      if (!aw_d && awready) begin aw_d = 1'b1; awvalid <= 1'b0; end
      if (!w_d && wready) begin w_d = 1'b1; wvalid <= 1'b0; end
      if (bvalid) begin b_d = 1'b1; r = bresp; end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_d, r_d;
    ar_d = 1'b0; r_d = 1'b0;
    araddr <= a; arvalid <= 1'b1;
    while (!r_d) begin
      @(posedge aclk);
      if (!ar_d && arready) begin ar_d = 1'b1; arvalid <= 1'b0; end
      if (rvalid) begin r_d = 1'b1; d = rdata; r = rresp; end
    end
  endtask : rd

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(what, exp, d);
    chk("rresp", {30'h0, `RESP_OKAY}, {30'h0, r});
  endtask : rchk

  task automatic key_lo(input logic [7:0] v);
    logic [1:0] r;
    wr(`OFFS_OSC_CONTROL, {24'h0, `KEY_LO_FIRST}, 4'h1, r);
    wr(`OFFS_OSC_CONTROL, {24'h0, `KEY_LO_SECOND}, 4'h1, r);
    wr(`OFFS_OSC_CONTROL, {24'h0, v}, 4'h1, r);
    chk("keyed bresp", {30'h0, `RESP_OKAY}, {30'h0, r});
  endtask : key_lo

  task automatic key_hi(input logic [7:0] v);
    logic [1:0] r;
    wr(`OFFS_OSC_CONTROL, {16'h0, `KEY_HI_FIRST, 8'h00}, 4'h2, r);
    wr(`OFFS_OSC_CONTROL, {16'h0, `KEY_HI_SECOND, 8'h00}, 4'h2, r);
    wr(`OFFS_OSC_CONTROL, {16'h0, v, 8'h00}, 4'h2, r);
  endtask : key_hi

  initial begin
    logic [31:0] d, ta, tb, v;
    logic [1:0]  r, ig;
    logic [2:0]  nx;
    logic [3:0]  exp_trim;
    void'($urandom(32'haf50b795));
    ig = 2'($urandom);
    initial_group <= ig;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // reset values and decoding
    rchk("control", `OFFS_OSC_CONTROL, ctl(3'h0, {1'b0, ig}, 8'h00));
    chk("current group", 32'h0, {29'h0, current_clock_group});
    rchk("trim a", `OFFS_TRIM_SEQ_A, 32'h0);
    rchk("trim b", `OFFS_TRIM_SEQ_B, 32'h0);
    rchk("random", `OFFS_RANDOM_TRIM, 32'h0);
    rd(8'h10, d, r);
    chk("unmapped rresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    wr(8'h14, 32'hFFFF, 4'hF, r);
    chk("unmapped bresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    $display("test reset done");
    // write protection: unkeyed, broken and keyed sequences
    wr(`OFFS_OSC_CONTROL, 32'hFFFF, 4'h3, r);
    rchk("unkeyed", `OFFS_OSC_CONTROL, ctl(3'h0, {1'b0, ig}, 8'h00));
    wr(`OFFS_OSC_CONTROL, {24'h0, `KEY_LO_FIRST}, 4'h1, r);
    wr(`OFFS_TRIM_SEQ_A, 32'h0, 4'h3, r);
    wr(`OFFS_OSC_CONTROL, {24'h0, `KEY_LO_SECOND}, 4'h1, r);
    wr(`OFFS_OSC_CONTROL, 32'h4, 4'h1, r);
    rchk("broken key", `OFFS_OSC_CONTROL, ctl(3'h0, {1'b0, ig}, 8'h00));
    nx = 3'($urandom_range(1, 3));
    key_hi({5'h0, nx});
    rchk("keyed high", `OFFS_OSC_CONTROL, ctl(3'h0, nx, 8'h00));
    $display("test protection done");
    // trim selection by roll index
    ta = $urandom & 32'hFFFF;
    tb = $urandom & 32'hFFFF;
    wr(`OFFS_TRIM_SEQ_A, ta, 4'h3, r);
    wr(`OFFS_TRIM_SEQ_B, tb, 4'h3, r);
    rchk("trim b rw", `OFFS_TRIM_SEQ_B, tb);
    key_lo(8'h04);
    for (int i = 0; i < 8; i++) begin
      roll_index <= 3'(i);
      repeat (3) @(posedge aclk);
      exp_trim = (i < 4) ? ta[4*i +: 4] : tb[4*(i-4) +: 4];
      chk("rc trim seq", {28'h0, exp_trim}, {28'h0, rc_trim});
    end
    key_lo(8'h00);
    roll_index <= 3'h5;
    repeat (3) @(posedge aclk);
    chk("rc trim base", {28'h0, ta[3:0]}, {28'h0, rc_trim});
    // random trim register and dithering
    wr(`OFFS_RANDOM_TRIM, 32'hFFFF, 4'h3, r);
    rchk("random top", `OFFS_RANDOM_TRIM, 32'h7FFF);
    v = $urandom & 32'h7FFF;
    wr(`OFFS_RANDOM_TRIM, v, 4'h3, r);
    rchk("random rw", `OFFS_RANDOM_TRIM, v);
    key_lo(8'h10);
    repeat (5) @(posedge aclk);
    rd(`OFFS_RANDOM_TRIM, d, r);
    checked++;
    if (d === v) begin err_count++; $display("Error dither expected change seen %h", d); end
    key_lo(8'h00);
    rd(`OFFS_RANDOM_TRIM, v, r);
    rchk("dither off", `OFFS_RANDOM_TRIM, v);
    chk("rc trim after dither", {28'h0, ta[3:0]}, {28'h0, rc_trim});
    $display("test trim done");
    // clock switch, then a redundant one
    pll_locked <= 1'b1;
    key_lo(8'h01);
    while (switch_busy !== 1'b1) @(posedge aclk);
    chk("switch target", {29'h0, nx}, {29'h0, switch_target});
    switch_ready <= 1'b1;
    while (switch_busy !== 1'b0) @(posedge aclk);
    switch_ready <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("current after switch", {29'h0, nx}, {29'h0, current_clock_group});
    rchk("after switch", `OFFS_OSC_CONTROL, ctl(nx, nx, {2'b0, nx[0], 5'h0}));
    key_lo(8'h01);
    repeat (3) @(posedge aclk);
    rchk("redundant", `OFFS_OSC_CONTROL, ctl(nx, nx, {2'b0, nx[0], 5'h0}));
    $display("test switch done");
    // monitored failure and its configuration gating
    clock_fail_detect <= 1'b1;
    @(posedge aclk);
    clock_fail_detect <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("current after fail", 32'h0, {29'h0, current_clock_group});
    rchk("fail flag", `OFFS_OSC_CONTROL, ctl(3'h0, nx, 8'h08));
    key_lo(8'h00);
    rchk("fail clear", `OFFS_OSC_CONTROL, ctl(3'h0, nx, 8'h00));
    switch_monitor_cfg <= 2'b01;
    clock_fail_detect <= 1'b1;
    @(posedge aclk);
    clock_fail_detect <= 1'b0;
    repeat (3) @(posedge aclk);
    rchk("monitor off", `OFFS_OSC_CONTROL, ctl(3'h0, nx, 8'h00));
    $display("test fail done");
    // configuration lock
    switch_monitor_cfg <= 2'b10;
    key_lo(8'h80);
    key_hi(8'h03);
    key_lo(8'h01);
    rchk("locked", `OFFS_OSC_CONTROL, ctl(3'h0, nx, 8'h80));
    key_lo(8'h00);
    rchk("lock sticky", `OFFS_OSC_CONTROL, ctl(3'h0, nx, 8'h80));
    switch_monitor_cfg <= 2'b01;
    key_hi(8'h03);
    rchk("lock open", `OFFS_OSC_CONTROL, ctl(3'h0, 3'h3, 8'h80));
    $display("test lock done");
    // reset in mid-run returns lock, group fields and random trim to their reset values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk("after mid reset", `OFFS_OSC_CONTROL, ctl(3'h0, {1'b0, ig}, 8'h00));
    rchk("random after reset", `OFFS_RANDOM_TRIM, 32'h0);
    $display("test mid reset done");
    summarize();
  end
endmodule : osc_ctrl_tb_top
